// file: sct_timer.sv
// slow clock timer: prescaler, counter/calendar, alarms, periodic events, apb registers
`timescale 1ns/1ps
module sct_timer
	import sct_pkg::*;
(
	input wire logic pclk, // bus clock, 100 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic system_rc_oscillator, // source 0 level
	input wire logic crystal_32khz_oscillator, // source 1 level
	input wire logic generic_clock_input, // source 3 level
	input wire logic one_khz_clock, // source 4 level
	input wire logic cpu_debug_halt, // processor halted in debug
	input wire logic run_in_debug, // global run-in-debug control
	input wire logic peripheral_debug_hold_mask, // this timer may run in debug
	output logic irq_overflow, // overflow request
	output logic [1:0] irq_periodic, // periodic requests
	output logic [1:0] irq_alarm, // alarm requests
	output logic irq_clock_switch_done, // clock switch done request
	output logic irq_ready // synchronization done request
);

	// ****************************************
	// state
	// ****************************************
	logic [31:0] prescaler_ff, counter_ff, control_ff, status_ff, mask_ff;
	logic [31:0] alarm_ff [2];
	logic [SCT_TAP_W-1:0] periodic_tap_select_ff [2];
	logic clk_cen_ff, clk_on_ff, clk_pending_ff, src_q_ff, busy_q_ff;
	logic [SCT_CLOCK_SOURCE_SELECT_W-1:0] clk_clock_source_select_ff, src_eff_ff;
	logic [3:0] sync_cnt_ff, clk_cnt_ff;
	sct_sync_state_type sync_state_ff;
	sct_sync_req_type sync_req_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic [6:0] irq_ff;

	// ****************************************
	// apb decode
	// ****************************************
	wire logic setup = psel & ~penable;
	wire logic wr_acc = psel & penable & pready_ff & pwrite;
	wire logic a_cr = paddr == SCT_CONTROL_REG_OFS;
	wire logic a_cv = paddr == SCT_COUNTER_VALUE_OFS;
	wire logic a_sr = paddr == SCT_STATUS_REG_OFS;
	wire logic a_scr = paddr == SCT_STATUS_CLEAR_OFS;
	wire logic a_ier = paddr == SCT_IRQ_ENABLE_SET_OFS;
	wire logic a_idr = paddr == SCT_IRQ_ENABLE_CLEAR_OFS;
	wire logic a_imr = paddr == SCT_IRQ_MASK_OFS;
	wire logic a_ar0 = paddr == SCT_ALARM_VALUE0_OFS;
	wire logic a_ar1 = paddr == SCT_ALARM_VALUE1_OFS;
	wire logic a_pi0 = paddr == SCT_PERIODIC_INTERVAL0_OFS;
	wire logic a_pi1 = paddr == SCT_PERIODIC_INTERVAL1_OFS;
	wire logic a_clk = paddr == SCT_CLOCK_CTRL_OFS;
	wire logic a_cal = paddr == SCT_CALENDAR_VALUE_OFS;
	wire logic a_sync = a_cr | a_cv | a_ar0 | a_ar1 | a_pi0 | a_pi1 | a_cal;
	wire logic mapped = a_sync | a_sr | a_scr | a_ier | a_idr | a_imr | a_clk;
	wire logic busy = sync_state_ff == SCT_SYNC_BUSY;

	// synchronized registers drop writes and read zero while busy
	wire logic sync_wr = wr_acc & a_sync & ~busy;
	wire logic clk_wr = wr_acc & a_clk & ~clk_pending_ff;
	wire logic [31:0] scr_clr = (wr_acc & a_scr) ? pwdata : 32'h0000_0000;

	// status read shows live busy bits beside sticky flags
	wire logic [31:0] sr_view = status_ff | ({31'h0000_0000, busy} << SCT_SR_BUSY)
		| ({31'h0000_0000, clk_pending_ff} << SCT_SR_CLOCK_SWITCH_PENDING);
	wire logic [31:0] clk_view = ({31'h0000_0000, clk_cen_ff} << SCT_CLK_CEN_BIT)
		| ({29'h0000_0000, clk_clock_source_select_ff} << SCT_CLK_CLOCK_SOURCE_SELECT_LSB);
	// counter is read straight, no skipped values within this bus clock
	wire logic [31:0] sync_view = a_cr ? control_ff : (a_cv | a_cal) ? counter_ff :
		a_ar0 ? alarm_ff[0] : a_ar1 ? alarm_ff[1] :
		a_pi0 ? {27'h000_0000, periodic_tap_select_ff[0]} : {27'h000_0000, periodic_tap_select_ff[1]};
	wire logic [31:0] rd_mux = a_sync ? (busy ? 32'h0000_0000 : sync_view) :
		a_sr ? sr_view : a_imr ? mask_ff : a_clk ? clk_view : 32'h0000_0000;

	// ****************************************
	// synchronizer for bus-side writes
	// ****************************************
	wire logic sync_apply = busy & (sync_cnt_ff == 4'h1);
	wire logic [7:0] ap_ofs = sync_req_ff.offset;
	wire logic [31:0] ap_dat = sync_req_ff.data;
	wire logic ap_cr = sync_apply & (ap_ofs == SCT_CONTROL_REG_OFS);
	wire logic ap_cnt = sync_apply & ((ap_ofs == SCT_COUNTER_VALUE_OFS) | (ap_ofs == SCT_CALENDAR_VALUE_OFS));
	wire logic prescaler_clear_apply = ap_cr & ap_dat[SCT_CR_PRESCALER_CLEAR_BIT];

	// write is captured, busy held for a fixed handshake delay, then applied
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_state_ff <= SCT_SYNC_IDLE;
			sync_cnt_ff <= 4'h0;
			sync_req_ff <= '0;
		end else begin
			case (sync_state_ff)
				SCT_SYNC_IDLE: begin
					if (sync_wr) begin
						sync_req_ff <= '{offset: paddr, data: pwdata};
						sync_cnt_ff <= SCT_SYNC_CYCLES;
						sync_state_ff <= SCT_SYNC_BUSY;
					end
				end
				SCT_SYNC_BUSY: begin
					sync_cnt_ff <= sync_cnt_ff - 4'h1;
					if (sync_apply) begin
						sync_state_ff <= SCT_SYNC_IDLE;
					end
				end
				default: begin
					sync_state_ff <= SCT_SYNC_IDLE;
				end
			endcase
		end
	end

	// applied values land in their registers; interval takes effect only here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_ff <= 32'h0000_0000;
			alarm_ff[0] <= 32'h0000_0000;
			alarm_ff[1] <= 32'h0000_0000;
			periodic_tap_select_ff[0] <= '0;
			periodic_tap_select_ff[1] <= '0;
		end else begin
			if (ap_cr) begin
				control_ff <= ap_dat & SCT_CR_WMASK & ~(32'h0000_0001 << SCT_CR_PRESCALER_CLEAR_BIT);
			end
			if (sync_apply && ap_ofs == SCT_ALARM_VALUE0_OFS) begin
				alarm_ff[0] <= ap_dat;
			end
			if (sync_apply && ap_ofs == SCT_ALARM_VALUE1_OFS) begin
				alarm_ff[1] <= ap_dat;
			end
			if (sync_apply && ap_ofs == SCT_PERIODIC_INTERVAL0_OFS) begin
				periodic_tap_select_ff[0] <= ap_dat[SCT_TAP_W-1:0];
			end
			if (sync_apply && ap_ofs == SCT_PERIODIC_INTERVAL1_OFS) begin
				periodic_tap_select_ff[1] <= ap_dat[SCT_TAP_W-1:0];
			end
		end
	end

	// ****************************************
	// prescaler clock control
	// ****************************************
	// enable and source only take effect after the pending window, so a
	// half-switched source never reaches the prescaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_cen_ff <= 1'b0;
			clk_clock_source_select_ff <= SCT_SRC_RC_OSC;
			clk_on_ff <= 1'b0;
			src_eff_ff <= SCT_SRC_RC_OSC;
			clk_pending_ff <= 1'b0;
			clk_cnt_ff <= 4'h0;
		end else begin
			if (clk_wr) begin
				clk_cen_ff <= pwdata[SCT_CLK_CEN_BIT];
				clk_clock_source_select_ff <= pwdata[SCT_CLK_CLOCK_SOURCE_SELECT_LSB +: SCT_CLOCK_SOURCE_SELECT_W];
				clk_pending_ff <= 1'b1;
				clk_cnt_ff <= SCT_CLK_SYNC_CYCLES;
			end else if (clk_pending_ff) begin
				clk_cnt_ff <= clk_cnt_ff - 4'h1;
				if (clk_cnt_ff == 4'h1) begin
					clk_pending_ff <= 1'b0;
					clk_on_ff <= clk_cen_ff;
					src_eff_ff <= clk_clock_source_select_ff;
				end
			end
		end
	end

	// source levels are sampled as ordinary inputs; bus clock means every cycle
	wire logic src_lvl = (src_eff_ff == SCT_SRC_RC_OSC) ? system_rc_oscillator :
		(src_eff_ff == SCT_SRC_XTAL_32K) ? crystal_32khz_oscillator :
		(src_eff_ff == SCT_SRC_GENERIC_CLOCK_INPUT) ? generic_clock_input :
		(src_eff_ff == SCT_SRC_1KHZ) ? one_khz_clock : 1'b0;
	wire logic src_rise = (src_eff_ff == SCT_SRC_BUS_CLK) | (src_lvl & ~src_q_ff);
	wire logic freeze = cpu_debug_halt & ~(run_in_debug & peripheral_debug_hold_mask);
	wire logic run = control_ff[SCT_CR_EN_BIT] & ~freeze;
	wire logic prsc_step = run & clk_on_ff & src_rise;

	// prescaler: not visible on the bus, only cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescaler_ff <= 32'h0000_0000;
			src_q_ff <= 1'b0;
		end else begin
			src_q_ff <= src_lvl;
			if (prescaler_clear_apply) begin
				prescaler_ff <= 32'h0000_0000;
			end else if (prsc_step) begin
				prescaler_ff <= prescaler_ff + 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// tap edges: counter tick and two periodic channels
	// ****************************************
	logic cnt_tick;
	logic [1:0] per_rise;
	sct_tap_edge #(.WIDTH(32), .SELW(SCT_TAP_W)) u_cnt_tap (
		.pclk(pclk),
		.presetn(presetn),
		.vec(prescaler_ff),
		.sel(control_ff[SCT_CR_PSEL_LSB +: SCT_TAP_W]),
		.gate(run),
		.rise(cnt_tick)
	);
	for (genvar g = 0; g < 2; g++) begin : g_per
		sct_tap_edge #(.WIDTH(32), .SELW(SCT_TAP_W)) u_per_tap (
			.pclk(pclk),
			.presetn(presetn),
			.vec(prescaler_ff),
			.sel(periodic_tap_select_ff[g]),
			.gate(run),
			.rise(per_rise[g])
		);
	end

	// ****************************************
	// counter and calendar
	// ****************************************
	// days in a month; the year offset is leap when divisible by four
	function automatic logic [4:0] month_days(input logic [3:0] mon, input logic [5:0] yr);
		logic [4:0] d;
		d = 5'h1F;
		if (mon == 4'h2) begin
			d = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
		end else if (mon == 4'h4 || mon == 4'h6 || mon == 4'h9 || mon == 4'hB) begin
			d = 5'h1E;
		end
		return d;
	endfunction

	// next second of the calendar; day and month count from one
	function automatic logic [31:0] cal_next(input logic [31:0] c);
		logic [5:0] s, m, y;
		logic [4:0] h, d;
		logic [3:0] mo;
		s = c[5:0];
		m = c[SCT_CAL_MIN_LSB +: 6];
		h = c[SCT_CAL_HOUR_LSB +: 5];
		d = c[SCT_CAL_DAY_LSB +: 5];
		mo = c[SCT_CAL_MONTH_LSB +: 4];
		y = c[SCT_CAL_YEAR_LSB +: 6];
		if (s != 6'h3B) begin
			s = s + 6'h01;
		end else begin
			s = 6'h00;
			if (m != 6'h3B) begin
				m = m + 6'h01;
			end else begin
				m = 6'h00;
				if (h != 5'h17) begin
					h = h + 5'h01;
				end else begin
					h = 5'h00;
					if (d < month_days(mo, y)) begin
						d = d + 5'h01;
					end else begin
						d = 5'h01;
						if (mo != 4'hC) begin
							mo = mo + 4'h1;
						end else begin
							mo = 4'h1;
							y = y + 6'h01;
						end
					end
				end
			end
		end
		return {y, mo, d, h, m, s};
	endfunction

	wire logic cal_mode = control_ff[SCT_CR_CAL_BIT];
	wire logic [31:0] cnt_inc = cal_mode ? cal_next(counter_ff) : counter_ff + 32'h0000_0001;
	// calendar overflow is the wrap of the year offset back to zero
	wire logic cnt_wrap = cal_mode ? (cal_next(counter_ff) < counter_ff) : (counter_ff == 32'hFFFF_FFFF);
	wire logic [1:0] alarm_hit = {2{cnt_tick}} & {cnt_inc == alarm_ff[1], cnt_inc == alarm_ff[0]};
	wire logic clr_on_alarm = |(alarm_hit & control_ff[SCT_CR_CA0_BIT +: 2]);
	wire logic ovf_evt = cnt_tick & (cnt_wrap | clr_on_alarm);

	// a software load wins over a tick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_ff <= 32'h0000_0000;
		end else if (ap_cnt) begin
			counter_ff <= ap_dat;
		end else if (cnt_tick) begin
			counter_ff <= clr_on_alarm ? 32'h0000_0000 : cnt_inc;
		end
	end

	// ****************************************
	// status, mask and interrupt lines
	// ****************************************
	wire logic rdy_evt = busy_q_ff & ~busy;
	wire logic clk_pend_q = clk_pending_ff;
	logic clk_q_ff;
	wire logic clkrdy_evt = clk_q_ff & ~clk_pend_q;
	wire logic [31:0] set_vec = ({31'h0000_0000, ovf_evt} << SCT_SR_OVF)
		| ({30'h0000_0000, alarm_hit} << SCT_SR_ALARM_MATCH_0)
		| ({30'h0000_0000, per_rise} << SCT_SR_PERIODIC_EVENT_0)
		| ({31'h0000_0000, rdy_evt} << SCT_SR_READY)
		| ({31'h0000_0000, clkrdy_evt} << SCT_SR_CLKRDY);
	// a new event beats a clear in the same cycle
	wire logic [31:0] nxt_status = ((status_ff & ~scr_clr) | set_vec) & SCT_STICKY_MASK;
	wire logic [31:0] nxt_mask = ((mask_ff | ((wr_acc & a_ier) ? pwdata : 32'h0000_0000))
		& ~((wr_acc & a_idr) ? pwdata : 32'h0000_0000)) & SCT_STICKY_MASK;
	wire logic [31:0] req = status_ff & mask_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= 32'h0000_0000;
			mask_ff <= 32'h0000_0000;
			busy_q_ff <= 1'b0;
			clk_q_ff <= 1'b0;
			irq_ff <= 7'h00;
		end else begin
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			busy_q_ff <= busy;
			clk_q_ff <= clk_pend_q;
			irq_ff <= {req[SCT_SR_CLKRDY], req[SCT_SR_READY], req[SCT_SR_ALARM_MATCH_0 +: 2],
				req[SCT_SR_PERIODIC_EVENT_0 +: 2], req[SCT_SR_OVF]};
		end
	end

	// ****************************************
	// apb response: zero-wait, data captured in setup
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~mapped;
			prdata_ff <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq_overflow = irq_ff[0];
	assign irq_periodic = irq_ff[2:1];
	assign irq_alarm = irq_ff[4:3];
	assign irq_ready = irq_ff[5];
	assign irq_clock_switch_done = irq_ff[6];

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_prsc_advance: assert property (prsc_step && !prescaler_clear_apply |=> prescaler_ff == $past(prescaler_ff) + 32'h0000_0001)
		else $error("prescaler did not advance on source edge");
	a_prsc_clear: assert property (prescaler_clear_apply |=> prescaler_ff == 32'h0000_0000)
		else $error("prescaler not cleared");
	a_debug_freeze: assert property (freeze && !prescaler_clear_apply |=> $stable(prescaler_ff) && !cnt_tick)
		else $error("prescaler moved during debug halt");
	a_ovf_wrap: assert property (cnt_tick && !cal_mode && counter_ff == 32'hFFFF_FFFF && !ap_cnt
		|=> counter_ff == 32'h0000_0000 && status_ff[SCT_SR_OVF])
		else $error("counter wrap did not set overflow");
	a_alarm_clear: assert property (clr_on_alarm && !ap_cnt |=> counter_ff == 32'h0000_0000 && status_ff[SCT_SR_OVF])
		else $error("clear on alarm failed");
	a_alarm_flag: assert property (alarm_hit[0] |=> status_ff[SCT_SR_ALARM_MATCH_0])
		else $error("alarm flag not set");
	a_per_flag: assert property (per_rise[1] |=> status_ff[SCT_SR_PERIODIC_EVENT_0 + 1])
		else $error("periodic flag not set");
	a_busy_ignore: assert property (busy && wr_acc && a_cr && !ap_cr |=> $stable(control_ff))
		else $error("write accepted while busy");
	a_irq_masked: assert property (!mask_ff[SCT_SR_OVF] |=> !irq_overflow)
		else $error("overflow request while masked");
	a_clk_done: assert property ($fell(clk_pending_ff) |=> status_ff[SCT_SR_CLKRDY])
		else $error("clock switch done not flagged");
	a_sync_len: assert property (sync_wr |=> busy [*3] ##1 !busy)
		else $error("busy window length wrong");
endmodule

// file: sct_pkg.sv
// constants, field layouts and carrier types for the slow clock timer
package sct_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] SCT_CONTROL_REG_OFS = 8'h00;
	localparam logic [7:0] SCT_COUNTER_VALUE_OFS = 8'h04;
	localparam logic [7:0] SCT_STATUS_REG_OFS = 8'h08;
	localparam logic [7:0] SCT_STATUS_CLEAR_OFS = 8'h0C;
	localparam logic [7:0] SCT_IRQ_ENABLE_SET_OFS = 8'h10;
	localparam logic [7:0] SCT_IRQ_ENABLE_CLEAR_OFS = 8'h14;
	localparam logic [7:0] SCT_IRQ_MASK_OFS = 8'h18;
	localparam logic [7:0] SCT_ALARM_VALUE0_OFS = 8'h20;
	localparam logic [7:0] SCT_ALARM_VALUE1_OFS = 8'h24;
	localparam logic [7:0] SCT_PERIODIC_INTERVAL0_OFS = 8'h30;
	localparam logic [7:0] SCT_PERIODIC_INTERVAL1_OFS = 8'h34;
	localparam logic [7:0] SCT_CLOCK_CTRL_OFS = 8'h40;
	localparam logic [7:0] SCT_CALENDAR_VALUE_OFS = 8'h54;

	// ****************************************
	// field positions
	// ****************************************
	localparam int SCT_CR_EN_BIT = 0;
	localparam int SCT_CR_PRESCALER_CLEAR_BIT = 1;
	localparam int SCT_CR_CAL_BIT = 2;
	localparam int SCT_CR_CA0_BIT = 8;
	localparam int SCT_CR_PSEL_LSB = 16;
	localparam int SCT_TAP_W = 5;
	localparam int SCT_CLK_CEN_BIT = 0;
	localparam int SCT_CLK_CLOCK_SOURCE_SELECT_LSB = 8;
	localparam int SCT_CLOCK_SOURCE_SELECT_W = 3;
	localparam logic [31:0] SCT_CR_WMASK = 32'h001F_0305;
	localparam logic [31:0] SCT_PIR_WMASK = 32'h0000_001F;

	localparam int SCT_SR_OVF = 0;
	localparam int SCT_SR_ALARM_MATCH_0 = 8;
	localparam int SCT_SR_PERIODIC_EVENT_0 = 16;
	localparam int SCT_SR_BUSY = 24;
	localparam int SCT_SR_READY = 25;
	localparam int SCT_SR_CLOCK_SWITCH_PENDING = 28;
	localparam int SCT_SR_CLKRDY = 29;
	localparam logic [31:0] SCT_STICKY_MASK = 32'h2203_0301;

	// calendar value: sec, min, hour, day, month, year offset
	localparam int SCT_CAL_MIN_LSB = 6;
	localparam int SCT_CAL_HOUR_LSB = 12;
	localparam int SCT_CAL_DAY_LSB = 17;
	localparam int SCT_CAL_MONTH_LSB = 22;
	localparam int SCT_CAL_YEAR_LSB = 26;

	// ****************************************
	// clock source encoding and timing
	// ****************************************
	localparam logic [2:0] SCT_SRC_RC_OSC = 3'h0;
	localparam logic [2:0] SCT_SRC_XTAL_32K = 3'h1;
	localparam logic [2:0] SCT_SRC_BUS_CLK = 3'h2;
	localparam logic [2:0] SCT_SRC_GENERIC_CLOCK_INPUT = 3'h3;
	localparam logic [2:0] SCT_SRC_1KHZ = 3'h4;
	localparam logic [3:0] SCT_SYNC_CYCLES = 4'h3;
	localparam logic [3:0] SCT_CLK_SYNC_CYCLES = 4'h4;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic [7:0] offset;
		logic [31:0] data;
	} sct_sync_req_type;

	typedef enum logic [1:0] {
		SCT_SYNC_IDLE = 2'b01,
		SCT_SYNC_BUSY = 2'b10
	} sct_sync_state_type;

endpackage

// file: sct_tap_edge.sv
// rising edge detector on one selectable bit of the prescaler
`timescale 1ns/1ps
module sct_tap_edge #(
	parameter int WIDTH = 32,
	parameter int SELW = 5
) (
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, active low
	input wire logic [WIDTH-1:0] vec, // prescaler value
	input wire logic [SELW-1:0] sel, // tap select
	input wire logic gate, // allow event
	output logic rise // one-cycle pulse on 0-to-1 of tap
);
	logic prev_ff;
	wire logic tap_bit = vec[sel];

	// previous tap level, so only true transitions count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= tap_bit;
		end
	end

	assign rise = gate & tap_bit & ~prev_ff;
endmodule

// file: test_sct_timer.sv
// self-checking bench for the slow clock timer
`timescale 1ns/1ps
module test_sct_timer;
	import sct_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, cpu_debug_halt, run_in_debug, peripheral_debug_hold_mask;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, lfsr, r;
	logic pready, pslverr, irq_overflow, irq_clock_switch_done, irq_ready;
	logic generic_clock_input_src;
	logic [1:0] irq_periodic, irq_alarm;
	logic [64:0] expq[$];
	logic [64:0] ent;
	logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h20, 8'h34, 8'h40, 8'h54};
	int err_total, total_checks;

	// three slow sources stay low; the generic clock input is pulsed by the bench in the last scenario
	sct_timer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.system_rc_oscillator(1'b0), .crystal_32khz_oscillator(1'b0), .generic_clock_input(generic_clock_input_src),
		.one_khz_clock(1'b0), .cpu_debug_halt, .run_in_debug, .peripheral_debug_hold_mask, .irq_overflow,
		.irq_periodic, .irq_alarm, .irq_clock_switch_done, .irq_ready);

	// 100 MHz bus clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ****************************************
	// checking and bus tasks
	// ****************************************
	function automatic logic [31:0] nxt_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one apb transfer; the expectation is noted before the request goes out
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] e, input logic er);
		expq.push_back({er, m, e});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, m, e, 1'b0);
	endtask

	// poll status until a busy bit drops; the watchdog bounds a hang
	task automatic wait_clr(input int b);
		do rd(8'h08, 32'h0, 32'h0); while (r[b] !== 1'b0);
	endtask

	task automatic sw(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		wait_clr(SCT_SR_BUSY);
	endtask

	// one clock control write, then wait for the pending bit to drop
	task automatic clk_step(input logic [31:0] d);
		wr(8'h40, d);
		wait_clr(SCT_SR_CLOCK_SWITCH_PENDING);
	endtask

	// scoreboard: each completed transfer retires the oldest note
	always @(posedge pclk) begin
		if ((psel & penable & pready) === 1'b1) begin
			ent = expq.size() > 0 ? expq.pop_front() : {1'b1, 64'h0};
			check({31'h0, pslverr}, {31'h0, ent[64]});
			check(prdata & ent[63:32], ent[31:0] & ent[63:32]);
		end
	end

	// a hang costs one mismatch and ends the run
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		close_out();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{psel, penable, pwrite, cpu_debug_halt, run_in_debug, peripheral_debug_hold_mask} = '0;
		generic_clock_input_src = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		lfsr = 32'h0000_8efc;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ofs[i]) rd(ofs[i], 32'hffff_ffff, 32'h0);
		xfer(1'b0, 8'h1C, 32'h0, 32'hffff_ffff, 32'h0, 1'b1);
		// clock procedure: source first, then enable, each time waiting for pending to drop
		wr(8'h40, 32'h0000_0200);
		rd(8'h08, 32'h1000_0000, 32'h1000_0000);
		wait_clr(SCT_SR_CLOCK_SWITCH_PENDING);
		rd(8'h08, 32'h2000_0000, 32'h2000_0000);
		wr(8'h10, 32'h2000_0000);
		@(posedge pclk);
		check({31'h0, irq_clock_switch_done}, 32'h1);
		wr(8'h0C, 32'h2000_0000);
		@(posedge pclk);
		check({31'h0, irq_clock_switch_done}, 32'h0);
		wr(8'h40, 32'h0000_0201);
		wait_clr(SCT_SR_CLOCK_SWITCH_PENDING);
		// halted counter holds a loaded value; reads during the transfer give zero
		cpu_debug_halt <= 1'b1;
		sw(8'h00, 32'h0002_0001);
		lfsr = nxt_rand(lfsr);
		wr(8'h04, lfsr);
		rd(8'h04, 32'hffff_ffff, 32'h0);
		wait_clr(SCT_SR_BUSY);
		rd(8'h08, 32'h0200_0000, 32'h0200_0000);
		wr(8'h10, 32'h0200_0000);
		@(posedge pclk);
		check({31'h0, irq_ready}, 32'h1);
		repeat (30) @(posedge pclk);
		rd(8'h04, 32'hffff_ffff, lfsr);
		// a control write that lands while the counter load is still busy must be dropped
		wr(8'h04, lfsr);
		wr(8'h00, 32'h0000_0004);
		rd(8'h00, 32'hffff_ffff, 32'h0002_0001);
		// wrap from the top at tap 2: about seven ticks, so the count stays below eight
		sw(8'h04, 32'hffff_fffc);
		wr(8'h0C, 32'hffff_ffff);
		wr(8'h10, 32'h0000_0001);
		cpu_debug_halt <= 1'b0;
		repeat (60) @(posedge pclk);
		cpu_debug_halt <= 1'b1;
		rd(8'h04, 32'hffff_fff8, 32'h0);
		rd(8'h08, 32'h0000_0001, 32'h0000_0001);
		check({31'h0, irq_overflow}, 32'h1);
		wr(8'h14, 32'h0000_0001);
		@(posedge pclk);
		check({31'h0, irq_overflow}, 32'h0);
		wr(8'h10, 32'h0000_0001);
		wr(8'h0C, 32'h0000_0001);
		@(posedge pclk);
		check({31'h0, irq_overflow}, 32'h0);
		rd(8'h08, 32'h0000_0001, 32'h0);
		// periodic channel 0 on prescaler bit 1
		sw(8'h30, 32'h0000_0001);
		wr(8'h10, 32'h0001_0000);
		wr(8'h0C, 32'h0001_0000);
		cpu_debug_halt <= 1'b0;
		repeat (12) @(posedge pclk);
		cpu_debug_halt <= 1'b1;
		rd(8'h08, 32'h0001_0000, 32'h0001_0000);
		check({31'h0, irq_periodic[0]}, 32'h1);
		// clear on alarm at 16: the sixteenth of thirty ticks clears the count to zero, so it stays below 16
		sw(8'h20, 32'h0000_0010);
		sw(8'h00, 32'h0000_0101);
		sw(8'h04, 32'h0);
		wr(8'h0C, 32'hffff_ffff);
		cpu_debug_halt <= 1'b0;
		repeat (60) @(posedge pclk);
		cpu_debug_halt <= 1'b1;
		rd(8'h04, 32'hffff_fff0, 32'h0);
		rd(8'h08, 32'h0000_0101, 32'h0000_0101);
		check({30'h0, irq_alarm}, 32'h0);
		// calendar across february 28 at midnight; the odd year runs by debug allowance
		sw(8'h00, 32'h0000_0005);
		// alarm in calendar form at midnight on march 1 of year 5
		sw(8'h20, {6'd5, 4'd3, 5'd1, 17'h0_0000});
		wr(8'h0C, 32'h0000_0100);
		wr(8'h10, 32'h0000_0100);
		for (int y = 4; y < 6; y++) begin
			sw(8'h54, {y[5:0], 4'd2, 5'd28, 5'd23, 6'd59, 6'd50});
			run_in_debug <= y[0];
			peripheral_debug_hold_mask <= y[0];
			cpu_debug_halt <= y[0];
			repeat (40) @(posedge pclk);
			{cpu_debug_halt, run_in_debug, peripheral_debug_hold_mask} <= 3'b100;
			rd(8'h54, 32'hffff_f000, {y[5:0], y[0] ? 9'd97 : 9'd93, 17'h0});
		end
		rd(8'h08, 32'h0000_0100, 32'h0000_0100);
		check({30'h0, irq_alarm}, 32'h1);
		// source switch: disable, new source, enable, each step waiting for pending to drop
		clk_step(32'h0000_0200);
		clk_step(32'h0000_0300);
		clk_step(32'h0000_0301);
		// prescaler cleared and counter zeroed; eight generic clock rises give four ticks at tap 0
		sw(8'h00, 32'h0000_0003);
		sw(8'h04, 32'h0000_0000);
		cpu_debug_halt <= 1'b0;
		repeat (8) begin
			generic_clock_input_src <= 1'b1;
			repeat (2) @(posedge pclk);
			generic_clock_input_src <= 1'b0;
			repeat (2) @(posedge pclk);
		end
		rd(8'h04, 32'hffff_ffff, 32'h0000_0004);
		close_out();
	end
endmodule
